// ===== hdl/usps_sequencer.sv
// phase sequencer top: step edge, phase state, sinks and boosts
`timescale 1ns/1ps
module usps_sequencer #(
  parameter int BOOST_CYCLES = usps_pkg::BOOST_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic STEP,
  input wire logic DIRECTION,
  input wire logic HALF_STEP_SELECT,
  input wire logic OUTPUT_DISABLE,
  output logic PHASE_A_SINK_FIRST,
  output logic PHASE_A_SINK_SECOND,
  output logic PHASE_B_SINK_FIRST,
  output logic PHASE_B_SINK_SECOND,
  output logic PHASE_A_BOOST_OUTPUT,
  output logic PHASE_B_BOOST_OUTPUT,
  output logic PHASE_A_ZERO,
  output logic PHASE_B_ZERO
);
  // one shared on-time for both timers, cut to the counter width
  localparam logic [usps_pkg::BOOST_W-1:0] DUR =
    BOOST_CYCLES[usps_pkg::BOOST_W-1:0];
  // number of phases, one timer and one sink pair each
  localparam int PHASES = 2;

  // step edge detector
  logic step_prev;
  logic next_step_prev;
  logic step_fall;
  // position in the eight-state half-step cycle
  logic [2:0] pos;
  logic [2:0] next_pos;
  // power-up gate, low for the first cycle after reset
  logic init_done;
  logic next_init_done;
  // drive codes now and after a pending step
  usps_pkg::usps_drive_t drive_a;
  usps_pkg::usps_drive_t drive_b;
  usps_pkg::usps_drive_t next_drive_a;
  usps_pkg::usps_drive_t next_drive_b;
  // per-phase timer trigger and state, index 0 is phase A
  logic [PHASES-1:0] trig;
  logic [PHASES-1:0] boost_on;
  // sinks may conduct
  logic sinks_ok;
  // next values of the output flip-flops
  logic next_a_first;
  logic next_a_second;
  logic next_b_first;
  logic next_b_second;
  logic next_a_boost;
  logic next_b_boost;
  logic next_a_zero;
  logic next_b_zero;

  // phase A code for a position; even positions energise both phases
  function automatic usps_pkg::usps_drive_t code_a(input logic [2:0] p);
    case (p)
      3'h0, 3'h6, 3'h7: code_a = usps_pkg::USPS_FIRST;
      3'h2, 3'h3, 3'h4: code_a = usps_pkg::USPS_SECOND;
      default: code_a = usps_pkg::USPS_ZERO;
    endcase
  endfunction : code_a

  // phase B code, a quarter cycle behind phase A
  function automatic usps_pkg::usps_drive_t code_b(input logic [2:0] p);
    case (p)
      3'h0, 3'h1, 3'h2: code_b = usps_pkg::USPS_FIRST;
      3'h4, 3'h5, 3'h6: code_b = usps_pkg::USPS_SECOND;
      default: code_b = usps_pkg::USPS_ZERO;
    endcase
  endfunction : code_b

  // falling edge of the step line; the idle level is high so a floating
  // pin can never produce a step, and no step counts before power-up
  always_comb begin
    next_step_prev = STEP;
    step_fall = init_done & step_prev & ~STEP;
  end

  // edge detector register
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      step_prev <= usps_pkg::STEP_IDLE;
    end else begin
      step_prev <= next_step_prev;
    end
  end

  // next position: direction and mode are read at the same edge as the
  // step, so a level change between steps never moves the motor
  always_comb begin
    next_pos = pos;
    if (step_fall) begin
      if (!HALF_STEP_SELECT) begin
        if (DIRECTION) begin
          next_pos = pos + 3'h1;
        end else begin
          next_pos = pos - 3'h1;
        end
      end else begin
        // full step lands on an even position from either parity
        if (DIRECTION) begin
          next_pos = (pos + 3'h2) & 3'h6;
        end else begin
          next_pos = (pos - 3'h1) & 3'h6;
        end
      end
    end
  end

  // position and power-up registers
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      pos <= usps_pkg::RESET_POS;
      init_done <= 1'h0;
    end else begin
      pos <= next_pos;
      init_done <= next_init_done;
    end
  end

  // power-up completes one cycle after reset is released
  always_comb begin
    next_init_done = 1'h1;
  end

  // drive codes and timer triggers; a phase whose code changes on this
  // step restarts its own timer, the other phase keeps counting
  always_comb begin
    drive_a = code_a(pos);
    drive_b = code_b(pos);
    next_drive_a = code_a(next_pos);
    next_drive_b = code_b(next_pos);
    trig[0] = step_fall & (next_drive_a != drive_a);
    trig[1] = step_fall & (next_drive_b != drive_b);
  end

  // one on-time counter per phase, both loaded from the same duration
  generate
    for (genvar ph = 0; ph < PHASES; ph++) begin : g_boost
      usps_boost_timer #(
        .WIDTH(usps_pkg::BOOST_W)
      ) timer (
        .clk(SYS_CLK),
        .rst(RESET),
        .trigger(trig[ph]),
        .duration(DUR),
        .active(boost_on[ph])
      );
    end
  endgenerate

  // output next values; sinks are gated by the inhibit level, the
  // zero flags keep reporting the phase logic while inhibited
  always_comb begin
    sinks_ok = init_done & ~OUTPUT_DISABLE;
    next_a_first = sinks_ok & (drive_a == usps_pkg::USPS_FIRST);
    next_a_second = sinks_ok & (drive_a == usps_pkg::USPS_SECOND);
    next_b_first = sinks_ok & (drive_b == usps_pkg::USPS_FIRST);
    next_b_second = sinks_ok & (drive_b == usps_pkg::USPS_SECOND);
    next_a_boost = init_done & boost_on[0];
    next_b_boost = init_done & boost_on[1];
    next_a_zero = init_done & (drive_a == usps_pkg::USPS_ZERO);
    next_b_zero = init_done & (drive_b == usps_pkg::USPS_ZERO);
  end

  // every output comes straight from a flip-flop; reset holds all off
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      PHASE_A_SINK_FIRST <= 1'h0;
      PHASE_A_SINK_SECOND <= 1'h0;
      PHASE_B_SINK_FIRST <= 1'h0;
      PHASE_B_SINK_SECOND <= 1'h0;
      PHASE_A_BOOST_OUTPUT <= 1'h0;
      PHASE_B_BOOST_OUTPUT <= 1'h0;
      PHASE_A_ZERO <= 1'h0;
      PHASE_B_ZERO <= 1'h0;
    end else begin
      PHASE_A_SINK_FIRST <= next_a_first;
      PHASE_A_SINK_SECOND <= next_a_second;
      PHASE_B_SINK_FIRST <= next_b_first;
      PHASE_B_SINK_SECOND <= next_b_second;
      PHASE_A_BOOST_OUTPUT <= next_a_boost;
      PHASE_B_BOOST_OUTPUT <= next_b_boost;
      PHASE_A_ZERO <= next_a_zero;
      PHASE_B_ZERO <= next_b_zero;
    end
  end

  // helper for the on-time checks: cycles since the last phase A
  // trigger, parked at full scale so an old trigger never matches
  logic [usps_pkg::BOOST_W-1:0] a_since;
  logic [usps_pkg::BOOST_W-1:0] next_a_since;

  always_comb begin
    next_a_since = a_since;
    if (trig[0]) begin
      next_a_since = '0;
    end else if (a_since != '1) begin
      next_a_since = a_since + 1'b1;
    end
  end

  // helper register
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      a_since <= '1;
    end else begin
      a_since <= next_a_since;
    end
  end

  // a step moves the position, nothing else does
  step_once_a: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    !step_fall |=> pos == $past(pos)
  ) else $error("position moved without a step");

  // a half step forward moves one position
  half_forward_a: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    step_fall && !HALF_STEP_SELECT && DIRECTION |=> pos == $past(pos) + 3'h1
  ) else $error("half step forward wrong");

  // a half step backward moves one position back
  half_backward_a: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    step_fall && !HALF_STEP_SELECT && !DIRECTION |=> pos == $past(pos) - 3'h1
  ) else $error("half step backward wrong");

  // a full step always ends with both phases on
  full_even_a: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    step_fall && HALF_STEP_SELECT |=> !pos[0]
  ) else $error("full step left a phase at zero");

  // a full step forward from a both-on position moves two positions
  full_forward_a: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    step_fall && HALF_STEP_SELECT && DIRECTION && !pos[0] |=>
      pos == $past(pos) + 3'h2
  ) else $error("full step forward wrong");

  // inhibit turns every sink off at the next edge
  inhibit_off_a: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    OUTPUT_DISABLE |=> !PHASE_A_SINK_FIRST && !PHASE_A_SINK_SECOND &&
      !PHASE_B_SINK_FIRST && !PHASE_B_SINK_SECOND
  ) else $error("sink on while inhibited");

  // a phase flagged at zero current has no sink on
  zero_a_flag_a: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    PHASE_A_ZERO |-> !PHASE_A_SINK_FIRST && !PHASE_A_SINK_SECOND
  ) else $error("phase A flagged zero with a sink on");

  // same for phase B
  zero_b_flag_a: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    PHASE_B_ZERO |-> !PHASE_B_SINK_FIRST && !PHASE_B_SINK_SECOND
  ) else $error("phase B flagged zero with a sink on");

  // a phase change turns the boost on two edges later
  boost_start_a: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    trig[0] |-> ##2 PHASE_A_BOOST_OUTPUT
  ) else $error("phase A boost did not start");

  // the boost stays on for the whole on-time after a trigger
  boost_hold_a: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    a_since != '0 && a_since <= DUR |-> PHASE_A_BOOST_OUTPUT
  ) else $error("phase A boost ended early");

  // and never outlasts it
  boost_end_a: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    PHASE_A_BOOST_OUTPUT |-> a_since <= DUR
  ) else $error("phase A boost ran too long");

  // no sink conducts before power-up completes
  power_up_a: assert property (
    @(posedge SYS_CLK)
    !init_done |=> !PHASE_A_SINK_FIRST && !PHASE_A_SINK_SECOND &&
      !PHASE_B_SINK_FIRST && !PHASE_B_SINK_SECOND
  ) else $error("sink on before power-up");

  // a full step forward was taken
  full_step_c: cover property (
    @(posedge SYS_CLK) disable iff (RESET)
    step_fall && HALF_STEP_SELECT && DIRECTION
  );

  // a half step backward was taken
  half_back_c: cover property (
    @(posedge SYS_CLK) disable iff (RESET)
    step_fall && !HALF_STEP_SELECT && !DIRECTION
  );

  // a step was taken while inhibited
  inhibit_step_c: cover property (
    @(posedge SYS_CLK) disable iff (RESET)
    step_fall && OUTPUT_DISABLE
  );

  // a boost ran to its end
  boost_done_c: cover property (
    @(posedge SYS_CLK) disable iff (RESET)
    $fell(PHASE_A_BOOST_OUTPUT)
  );
endmodule : usps_sequencer

// ===== hdl/usps_pkg.sv
// constants and types for the unipolar stepper phase sequencer
// How it works
// - one step per falling step edge only
// - half_step_select low gives half steps
// - two half-step pulses make one full step
// - direction and mode sampled at falling edge
// - direction picks forward or backward sequence
// - output_disable high forces all sinks off
// - unconnected logic inputs read as high
// - boost output on timed after phase change
// - boost time about 0.55 times RT CT
// - zero-current indication per phase A and B
// - two sinks plus one boost per phase
// - phase change triggers that phase's timer
// - two independent timers sharing one setting
// - reset initialises logic, holds outputs inhibited
// - zero flag while phase current suppressed
package usps_pkg;
  // clock rate and boost time in their own units
  localparam int CLK_HZ = 10000000;
  localparam int BOOST_NS = 260000;
  // 0.55 * 47k * 10n, rounded up for a longest-type time
  localparam int BOOST_CYCLES = BOOST_NS / (1000000000 / CLK_HZ);
  localparam int BOOST_W = 16;
  localparam logic [2:0] RESET_POS = 3'h0;
  // step line level after reset, same as an open pin
  localparam logic STEP_IDLE = 1'h1;
  // drive codes per phase: first sink, second sink, zero current
  typedef enum logic [2:0] {
    USPS_FIRST = 3'h1,
    USPS_SECOND = 3'h2,
    USPS_ZERO = 3'h4
  } usps_drive_t;
endpackage : usps_pkg

// ===== hdl/usps_boost_timer.sv
// one retriggerable boost on-time counter for a single phase
`timescale 1ns/1ps
module usps_boost_timer #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic trigger,
  input wire logic [WIDTH-1:0] duration,
  output logic active
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;

  // reload on every trigger so a fast step rate extends the pulse
  always_comb begin
    next_count = count;
    if (trigger) begin
      next_count = duration;
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign active = (count != '0);

  // a trigger always restarts the count from the full duration
  reload_count_a: assert property (
    @(posedge clk) disable iff (rst)
    trigger |=> count == $past(duration)
  ) else $error("boost timer did not reload");
endmodule : usps_boost_timer

// ===== bench/usps_step_source.sv
// controller model issuing step pulses
`timescale 1ns/1ps
module usps_step_source (
  input wire logic go,
  output logic step
);
  // step idles high and falls only when go rises
  assign step = ~go;
endmodule : usps_step_source

// ===== bench/usps_sequencer_bench.sv
// bench for the phase sequencer
`timescale 1ns/1ps
module usps_sequencer_bench;
  // short on-time keeps the boost scenario brief
  localparam int BOOST = 20;
  logic SYS_CLK = 1'h0;
  logic RESET = 1'h1;
  logic DIRECTION = 1'h1;
  logic HALF_STEP_SELECT = 1'h1;
  logic OUTPUT_DISABLE = 1'h0;
  logic go = 1'h0;
  logic STEP;
  logic PHASE_A_SINK_FIRST;
  logic PHASE_A_SINK_SECOND;
  logic PHASE_B_SINK_FIRST;
  logic PHASE_B_SINK_SECOND;
  logic PHASE_A_BOOST_OUTPUT;
  logic PHASE_B_BOOST_OUTPUT;
  logic PHASE_A_ZERO;
  logic PHASE_B_ZERO;
  int mismatches = 0;
  int total_checks = 0;
  // sinks as {A1, A2, B1, B2}; flags as {boost A, boost B, zero A, zero B}
  wire [3:0] s = {PHASE_A_SINK_FIRST, PHASE_A_SINK_SECOND,
    PHASE_B_SINK_FIRST, PHASE_B_SINK_SECOND};
  wire [3:0] flags = {PHASE_A_BOOST_OUTPUT, PHASE_B_BOOST_OUTPUT,
    PHASE_A_ZERO, PHASE_B_ZERO};
  always #50 SYS_CLK = ~SYS_CLK;
  usps_step_source src (.go(go), .step(STEP));
  usps_sequencer #(.BOOST_CYCLES(BOOST)) uut (
    .SYS_CLK(SYS_CLK),
    .RESET(RESET),
    .STEP(STEP),
    .DIRECTION(DIRECTION),
    .HALF_STEP_SELECT(HALF_STEP_SELECT),
    .OUTPUT_DISABLE(OUTPUT_DISABLE),
    .PHASE_A_SINK_FIRST(PHASE_A_SINK_FIRST),
    .PHASE_A_SINK_SECOND(PHASE_A_SINK_SECOND),
    .PHASE_B_SINK_FIRST(PHASE_B_SINK_FIRST),
    .PHASE_B_SINK_SECOND(PHASE_B_SINK_SECOND),
    .PHASE_A_BOOST_OUTPUT(PHASE_A_BOOST_OUTPUT),
    .PHASE_B_BOOST_OUTPUT(PHASE_B_BOOST_OUTPUT),
    .PHASE_A_ZERO(PHASE_A_ZERO),
    .PHASE_B_ZERO(PHASE_B_ZERO)
  );
  task automatic chk(string nm, logic [3:0] seen, logic [3:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // callers start and end 1 ns after an edge; mode lines change only
  // a full clock away from the falling step edge
  task automatic pulse(int n);
    repeat (n) begin
      go = 1'h1;
      repeat (3) @(posedge SYS_CLK);
      #1 go = 1'h0;
      repeat (3) @(posedge SYS_CLK);
      #1;
    end
  endtask : pulse
  // let n edges pass, then step off the edge
  task automatic settle(int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask : settle
  // state right after reset
  task automatic t_rest;
    settle(2);
    chk("rest sinks", s, 4'hA);
    chk("rest flags", flags, 4'h0);
    $display("test rest done");
  endtask : t_rest
  // full steps forward and the boost on-time
  task automatic t_full;
    pulse(1);
    chk("full one", s, 4'h6);
    chk("boost on", flags, 4'h8);
    settle(BOOST + 5);
    chk("boost off", flags, 4'h0);
    pulse(3);
    chk("full four", s, 4'hA);
    $display("test full done");
  endtask : t_full
  // full step backward and back again
  task automatic t_full_back;
    DIRECTION = 1'h0;
    settle(1);
    pulse(1);
    chk("full back", s, 4'h9);
    DIRECTION = 1'h1;
    settle(1);
    pulse(1);
    chk("full return", s, 4'hA);
    $display("test full back done");
  endtask : t_full_back
  // half steps both ways, zero flags, and full step from odd position
  task automatic t_half;
    HALF_STEP_SELECT = 1'h0;
    settle(1);
    pulse(1);
    chk("half one", s, 4'h2);
    chk("zero a", {2'h0, flags[1:0]}, 4'h2);
    pulse(7);
    chk("half eight", s, 4'hA);
    DIRECTION = 1'h0;
    settle(1);
    pulse(1);
    chk("half back", s, 4'h8);
    chk("zero b", {2'h0, flags[1:0]}, 4'h1);
    DIRECTION = 1'h1;
    HALF_STEP_SELECT = 1'h1;
    settle(1);
    pulse(1);
    chk("odd to full", s, 4'hA);
    $display("test half done");
  endtask : t_half
  // inhibit blanks sinks while the phase logic still steps
  task automatic t_inhibit;
    OUTPUT_DISABLE = 1'h1;
    settle(2);
    chk("inhibit", s, 4'h0);
    pulse(1);
    chk("inhibit step", s, 4'h0);
    OUTPUT_DISABLE = 1'h0;
    settle(2);
    chk("inhibit end", s, 4'h6);
    $display("test inhibit done");
  endtask : t_inhibit
  // reset in mid-run
  task automatic t_reset;
    RESET = 1'h1;
    settle(1);
    chk("reset off", s, 4'h0);
    settle(4);
    RESET = 1'h0;
    settle(2);
    chk("reset home", s, 4'hA);
    $display("test reset done");
  endtask : t_reset
  task automatic wrap_up;
    $display("%0d checks %0d failed", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (5) @(posedge SYS_CLK);
    #1 RESET = 1'h0;
    t_rest;
    t_full;
    t_full_back;
    t_half;
    t_inhibit;
    t_reset;
    wrap_up;
  end
  // watchdog cuts a hang short
  initial begin
    #100000;
    mismatches++;
    wrap_up;
  end
endmodule : usps_sequencer_bench
